// File: core/reset_clock_irq_pin_logic.sv
// Function
// - External low on reset pin resets all internal logic to startup state; here it asserts core_rst and clears ctrl, status and mask keep their values
// - Watchdog or clock monitor failure pulls reset pin low, open drain
// - Pin high within two bus-phase cycles means internal reset, else external
// - Bus-phase clock runs at one quarter of oscillator rate
// - Low phase is internal processing, high phase is data access
// - Stop mode halts all clocks including bus-phase output
// - Single-chip modes allow disabling bus-phase clock output pin
// - Fixed-clock variant keeps bus-phase output on, ignores disable
// - Interrupt input takes async requests, edge or level by config bit
// - Every reset returns interrupt input to level-sensitive mode
//
// Purpose: Reset pin, reset classification, bus-phase clock and interrupt input logic
// Assumes: Pins synchronous to core_clk except where synchronisers are shown
// Notes: Registers on a plain strobe port; read data one cycle after read strobe
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module reset_clock_irq_pin_logic #(
	parameter bit FIXED_CLK_VARIANT = 1'b0
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	input wire logic watchdog_monitor_fail,
	input wire logic clock_monitor_fail,
	input wire logic irq_n_in,
	input wire logic irq_ack,
	input wire rcip_pkg::reg_req_t reg_req,
	output logic [rcip_pkg::DATA_W-1:0] reg_rdata,
	output logic core_rst,
	output logic phase_clk,
	output logic phase_clk_pin,
	output logic access_phase,
	output logic irq_req,
	output logic int_out
);
	import rcip_pkg::*;

	logic rst_sync1;
	logic rst_sync2;
	logic irq_sync1;
	logic irq_sync2;
	logic irq_prev;
	logic edge_pend;
	rst_state_t rst_state;
	rst_state_t next_rst_state;
	logic [3:0] rst_cnt;
	logic [3:0] next_rst_cnt;
	logic [7:0] ctrl;
	logic [EV_N-1:0] status;
	logic [EV_N-1:0] mask;
	logic [1:0] div_cnt;
	logic [1:0] hist_wp;
	logic [1:0] hist_rd;
	logic last_internal;

	// Register decode
	wire wr_ctrl = reg_req.wr && reg_req.addr == OFS_CTRL;
	wire wr_status = reg_req.wr && reg_req.addr == OFS_STATUS;
	wire wr_mask = reg_req.wr && reg_req.addr == OFS_MASK;
	wire rd_any = reg_req.rd;
	wire in_reset = rst_state != RST_RUN;
	wire fail = watchdog_monitor_fail || clock_monitor_fail;
	wire edge_mode = ctrl[CTRL_EDGE];
	wire stopped = ctrl[CTRL_STOP];
	// Disable honoured only in single-chip mode and not on the fixed variant
	wire clk_off = ctrl[CTRL_CLK_OFF] && ctrl[CTRL_SINGLE] && !FIXED_CLK_VARIANT;
	wire fall_seen = irq_prev && !irq_sync2;
	wire irq_level = !irq_sync2;
	wire next_irq = edge_mode ? (edge_pend || fall_seen) : irq_level;
	wire classify_done = rst_state == RST_CLASSIFY &&
		(rst_sync2 || rst_cnt == 4'(CLASSIFY_CYCLES));
	wire ev_int_rst = rst_state == RST_CLASSIFY && rst_sync2;
	wire ev_ext_rst = classify_done && !rst_sync2;
	wire ev_irq = next_irq && !irq_req;
	wire ev_fail = fail && rst_state == RST_RUN;
	wire [EV_N-1:0] ev = {ev_fail, ev_ext_rst, ev_int_rst, ev_irq};
	wire [EV_N-1:0] next_status = (status & ~(wr_status ? reg_req.wdata[EV_N-1:0] : '0)) | ev;
	wire next_int = |(next_status & mask);
	wire [1:0] next_div = div_cnt + 2'h1;
	wire next_phase = div_cnt[1];

	// Read mux
	logic [7:0] rd_mux;
	always_comb begin
		unique case (reg_req.addr)
			OFS_CTRL: rd_mux = ctrl;
			OFS_STATUS: rd_mux = {4'h0, status};
			OFS_MASK: rd_mux = {4'h0, mask};
			OFS_STATE: rd_mux = {3'h0, last_internal, hist_rd, rst_sync2, in_reset};
			default: rd_mux = 8'h00;
		endcase
	end

	// Reset sequencer: hold, drive on failure, then classify pin release
	always_comb begin
		next_rst_state = rst_state;
		next_rst_cnt = rst_cnt;
		unique case (rst_state)
			RST_RUN: begin
				if (fail) begin
					next_rst_state = RST_DRIVE;
					next_rst_cnt = 4'h0;
				end else if (!rst_sync2) begin
					next_rst_state = RST_HOLD;
				end
			end
			RST_DRIVE: begin
				next_rst_cnt = rst_cnt + 4'h1;
				if (rst_cnt == 4'(FAIL_DRIVE_CYCLES - 1)) begin
					next_rst_state = RST_CLASSIFY;
					next_rst_cnt = 4'h0;
				end
			end
			RST_HOLD: begin
				// Only a sampled high releases reset
				if (rst_sync2) begin
					next_rst_state = RST_RUN;
				end
			end
			RST_CLASSIFY: begin
				next_rst_cnt = rst_cnt + 4'h1;
				if (rst_sync2) begin
					next_rst_state = RST_RUN;
				end else if (classify_done) begin
					next_rst_state = RST_HOLD;
				end
			end
		endcase
	end

	// Two-stage synchronisers for the pins
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rst_sync1 <= 1'b0;
			rst_sync2 <= 1'b0;
			irq_sync1 <= 1'b1;
			irq_sync2 <= 1'b1;
		end else if (clk_en) begin
			rst_sync1 <= reset_pin_in;
			rst_sync2 <= rst_sync1;
			irq_sync1 <= irq_n_in;
			irq_sync2 <= irq_sync1;
		end
	end

	// Reset state and pin driver
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rst_state <= RST_HOLD;
			rst_cnt <= 4'h0;
			reset_pin_oe <= 1'b0;
			reset_pin_out <= 1'b0;
			core_rst <= 1'b1;
		end else if (clk_en) begin
			rst_state <= next_rst_state;
			rst_cnt <= next_rst_cnt;
			reset_pin_oe <= next_rst_state == RST_DRIVE;
			reset_pin_out <= 1'b0;
			core_rst <= next_rst_state != RST_RUN;
		end
	end

	// Control: any reset returns the input to level mode; frozen with the enable low
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl <= CTRL_RESET;
		end else if (clk_en) begin
			if (in_reset) begin
				ctrl <= CTRL_RESET;
			end else if (wr_ctrl) begin
				ctrl <= reg_req.wdata;
			end
		end
	end

	// Interrupt input tracking; edge latch holds until acknowledged
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq_prev <= 1'b1;
			edge_pend <= 1'b0;
			irq_req <= 1'b0;
		end else if (clk_en) begin
			irq_prev <= irq_sync2;
			// A new edge in the ack cycle is kept
			edge_pend <= edge_mode && (fall_seen || (edge_pend && !irq_ack));
			irq_req <= next_irq && !in_reset;
		end
	end

	// Sticky status, mask, interrupt line
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			status <= '0;
			mask <= MASK_RESET;
			int_out <= 1'b0;
		end else if (clk_en) begin
			status <= next_status;
			if (wr_mask) begin
				mask <= reg_req.wdata[EV_N-1:0];
			end
			int_out <= next_int;
		end
	end

	// Divide by four; frozen in stop mode, pin gated when disabled
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			div_cnt <= 2'h0;
			phase_clk <= 1'b0;
			phase_clk_pin <= 1'b0;
			access_phase <= 1'b0;
		end else if (clk_en && !stopped) begin
			div_cnt <= next_div;
			phase_clk <= next_phase;
			phase_clk_pin <= next_phase && !clk_off;
			access_phase <= next_phase;
		end
	end

	// Read data, reset cause memory pointer
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
			hist_wp <= 2'h0;
			last_internal <= 1'b0;
		end else if (clk_en) begin
			reg_rdata <= rd_any ? rd_mux : 8'h00;
			if (ev_int_rst || ev_ext_rst) begin
				hist_wp <= hist_wp + 2'h1;
				last_internal <= ev_int_rst;
			end
		end
	end

	// Last four reset causes; bit0 internal, bit1 valid
	rcip_hist_mem u_hist (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.wr_en(ev_int_rst || ev_ext_rst),
		.wr_addr(hist_wp),
		.wr_data({1'b1, ev_int_rst}),
		.rd_addr(hist_wp - 2'h1),
		.rd_data(hist_rd)
	);
endmodule
`default_nettype wire

// File: core/rcip_pkg.sv
// Purpose: Shared constants and types for reset, bus-phase clock and interrupt pin logic
// Assumes: One core clock at 25 MHz standing in for the oscillator input
// Notes: Register offsets are word indices on the plain register port
package rcip_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	// Register offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h1;
	localparam logic [3:0] OFS_MASK = 4'h2;
	localparam logic [3:0] OFS_STATE = 4'h3;
	// Control field positions
	localparam int CTRL_EDGE = 0;
	localparam int CTRL_CLK_OFF = 1;
	localparam int CTRL_STOP = 2;
	localparam int CTRL_SINGLE = 3;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Status / mask field positions
	localparam int EV_IRQ = 0;
	localparam int EV_INT_RST = 1;
	localparam int EV_EXT_RST = 2;
	localparam int EV_FAIL = 3;
	localparam int EV_N = 4;
	localparam logic [3:0] MASK_RESET = 4'h0;
	// Bus-phase clock: oscillator divided by four
	localparam int PHASE_DIV = 4;
	localparam int CLASSIFY_E_CYCLES = 2;
	localparam int CLASSIFY_CYCLES = PHASE_DIV * CLASSIFY_E_CYCLES;
	// Failure pulse stretch on the reset pin, in core cycles
	localparam int FAIL_DRIVE_CYCLES = 4;
	localparam int HIST_DEPTH = 4;

	typedef enum logic [1:0] {
		RST_RUN,
		RST_HOLD,
		RST_DRIVE,
		RST_CLASSIFY
	} rst_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
endpackage

// File: core/rcip_hist_mem.sv
// Purpose: Small record of the last reset causes, registered read port
// Assumes: Single clock, one write per cycle at most
// Notes: Data out comes from a flip-flop
`timescale 1ns/1ps
`default_nettype none
module rcip_hist_mem (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic wr_en,
	input wire logic [1:0] wr_addr,
	input wire logic [1:0] wr_data,
	input wire logic [1:0] rd_addr,
	output logic [1:0] rd_data
);
	logic [1:0] mem [4];

	// Storage and registered read
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rd_data <= 2'h0;
		end else if (clk_en) begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			rd_data <= mem[rd_addr];
		end
	end
endmodule
`default_nettype wire

// File: dv/rcip_board.sv
// Purpose: Board model with pulled-up reset and interrupt lines
// Assumes: Every party sinks a line through an open-drain driver
// Notes: Released lines rise to the pull-up level, never hold old values
`timescale 1ns/1ps
`default_nettype none
module rcip_board (
	input wire logic pin_oe,
	input wire logic ext_low,
	input wire logic [1:0] src_low
	,output logic reset_pin
	,output logic irq_n
);
	// Wired-AND lines with pull-ups; the device only sinks
	assign reset_pin = !(pin_oe || ext_low);
	assign irq_n = !(|src_low);
endmodule
`default_nettype wire

// File: dv/rcip_chk_chk.sv
// Purpose: Port-level checks on reset pin and bus-phase clock
// Assumes: One clock domain, sys_rst synchronous active high
// Notes: Attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module rcip_chk (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic reset_pin_in,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe,
	input wire logic watchdog_monitor_fail,
	input wire logic clock_monitor_fail,
	input wire rcip_pkg::reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic core_rst,
	input wire logic phase_clk,
	input wire logic access_phase,
	input wire logic phase_clk_pin
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// Failure drive holds the pin for its full stretch
	sequence s_drive;
		reset_pin_oe [*4];
	endsequence
	chk_open_drain_low: assert property (reset_pin_oe |-> !reset_pin_out)
		else $error("reset pin driven high");
	chk_pin_gated_clock: assert property (phase_clk_pin |-> phase_clk)
		else $error("phase clock pin high while phase clock low");
	chk_access_phase_match: assert property (access_phase == phase_clk)
		else $error("access phase differs from phase clock");
	chk_phase_half_width: assert property (clk_en && $changed(phase_clk) |=> $stable(phase_clk))
		else $error("phase clock level shorter than two cycles");
	chk_drive_stretch: assert property ($rose(reset_pin_oe) |-> s_drive)
		else $error("failure drive too short");
	chk_fail_drives_pin: assert property ((watchdog_monitor_fail || clock_monitor_fail)
		&& clk_en && !core_rst && !reset_pin_oe |-> ##[1:2] reset_pin_oe)
		else $error("failure did not drive reset pin");
	chk_drive_core_rst: assert property ($rose(reset_pin_oe) |-> ##[0:4] core_rst)
		else $error("internal reset missing on failure");
	chk_ext_pin_hold: assert property ((!reset_pin_in && clk_en) [*5] |-> core_rst)
		else $error("low reset pin did not hold core");
	chk_release_synced: assert property ($fell(core_rst) |-> $past(reset_pin_in, 2))
		else $error("core released before pin sampled high");
	chk_rdata_idle: assert property ($past(clk_en) && !$past(reg_req.rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
endmodule
bind reset_clock_irq_pin_logic rcip_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
	.clk_en(clk_en), .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
	.reset_pin_oe(reset_pin_oe), .watchdog_monitor_fail(watchdog_monitor_fail),
	.clock_monitor_fail(clock_monitor_fail), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.core_rst(core_rst), .phase_clk(phase_clk), .access_phase(access_phase),
	.phase_clk_pin(phase_clk_pin));
`default_nettype wire

// File: dv/tb_reset_clock_irq_pin_logic.sv
// Purpose: Self-checking bench for reset, phase clock and interrupt pin logic
// Assumes: Board model supplies the pulled-up pins
// Notes: Random pulse widths from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb_reset_clock_irq_pin_logic;
	import rcip_pkg::*;
	logic core_clk = 0, sys_rst = 1, clk_en = 1, wdf = 0, cmf = 0, irq_ack = 0, ext_low = 0;
	logic [1:0] src_low = 0;
	reg_req_t reg_req = '0;
	wire logic pin, irq_n, oe, pout, core_rst, ph, ph_pin, acc, irq_req, int_out;
	wire logic [7:0] rdata;
	int fails = 0, tests_run = 0, cyc = 0, na, nb;
	logic [7:0] d;
	rcip_board board (.pin_oe(oe), .ext_low(ext_low), .src_low(src_low), .reset_pin(pin),
		.irq_n(irq_n));
	reset_clock_irq_pin_logic #(.FIXED_CLK_VARIANT(1'b0)) dut (.core_clk(core_clk),
		.sys_rst(sys_rst), .clk_en(clk_en), .reset_pin_in(pin), .reset_pin_out(pout),
		.reset_pin_oe(oe), .watchdog_monitor_fail(wdf), .clock_monitor_fail(cmf),
		.irq_n_in(irq_n), .irq_ack(irq_ack), .reg_req(reg_req), .reg_rdata(rdata),
		.core_rst(core_rst), .phase_clk(ph), .phase_clk_pin(ph_pin), .access_phase(acc),
		.irq_req(irq_req), .int_out(int_out));
	initial forever #20 core_clk = ~core_clk;
	// Hang guard, well above the run length
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			finish_test();
		end
	end
	function automatic logic [7:0] bit_of(input int b);
		return 8'h01 << b;
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge core_clk) reg_req <= {a, v, 2'b10};
		@(posedge core_clk) reg_req <= '0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge core_clk) reg_req <= {a, 8'h00, 2'b01};
		@(posedge core_clk) reg_req <= '0;
		#1 d = rdata;
	endtask
	task automatic settle;
		for (int i = 0; i < 80 && core_rst !== 1'b0; i++) @(posedge core_clk);
	endtask
	// Counts rises of the phase clock and its pin over 40 cycles
	task automatic rises;
		logic pa, pb;
		na = 0;
		nb = 0;
		@(posedge core_clk) #1 {pa, pb} = {ph, ph_pin};
		repeat (40) begin
			@(posedge core_clk) #1 na += int'(ph && !pa);
			nb += int'(ph_pin && !pb);
			{pa, pb} = {ph, ph_pin};
		end
	endtask
	task automatic finish_test;
		if (fails == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h395F));
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		settle();
		rd(OFS_CTRL); chk(d, CTRL_RESET, "ctrl");
		rd(4'hF); chk(d, 8'h00, "unmapped");
		rises(); chk(8'(na), 8'(40 / PHASE_DIV), "phase");
		chk(8'(nb), 8'(40 / PHASE_DIV), "phase pin");
		// Shared line, level mode, masked in
		wr(OFS_MASK, bit_of(EV_IRQ));
		src_low <= 2'b11;
		repeat (6) @(posedge core_clk);
		chk(8'(irq_req), 8'h01, "level irq");
		chk(8'(int_out), 8'h01, "int out");
		src_low <= 2'b00;
		repeat (6) @(posedge core_clk);
		chk(8'(irq_req), 8'h00, "level idle");
		wr(OFS_STATUS, 8'hFF);
		wr(OFS_MASK, 8'h00);
		repeat (2) @(posedge core_clk);
		chk(8'(int_out), 8'h00, "int cleared");
		// Edge mode keeps a short pulse pending until acknowledged
		wr(OFS_CTRL, bit_of(CTRL_EDGE));
		src_low <= 2'b01;
		repeat (3 + $urandom_range(4)) @(posedge core_clk);
		src_low <= 2'b00;
		repeat (6) @(posedge core_clk);
		chk(8'(irq_req), 8'h01, "edge latch");
		chk(8'(int_out), 8'h00, "masked");
		@(posedge core_clk) irq_ack <= 1'b1;
		@(posedge core_clk) irq_ack <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk(8'(irq_req), 8'h00, "edge ack");
		wr(OFS_CTRL, 8'h0A);
		rises(); chk(8'(nb), 8'h00, "pin off");
		chk(8'(na), 8'(40 / PHASE_DIV), "phase on");
		wr(OFS_CTRL, bit_of(CTRL_STOP));
		rises(); chk(8'(na), 8'h00, "stopped");
		// Watchdog failure, pin released promptly
		wr(OFS_STATUS, 8'hFF);
		@(posedge core_clk) wdf <= 1'b1;
		@(posedge core_clk) wdf <= 1'b0;
		repeat (4) @(posedge core_clk);
		settle();
		rd(OFS_STATUS); chk(d & bit_of(EV_INT_RST), bit_of(EV_INT_RST), "internal");
		rd(OFS_CTRL); chk(d, CTRL_RESET, "ctrl again");
		rises(); chk(8'(na), 8'(40 / PHASE_DIV), "restarted");
		// Clock monitor failure while the board holds the pin
		wr(OFS_STATUS, 8'hFF);
		ext_low <= 1'b1;
		@(posedge core_clk) cmf <= 1'b1;
		@(posedge core_clk) cmf <= 1'b0;
		repeat (20 + $urandom_range(10)) @(posedge core_clk);
		chk(8'(core_rst), 8'h01, "held");
		ext_low <= 1'b0;
		settle();
		rd(OFS_STATUS); chk(d & bit_of(EV_EXT_RST), bit_of(EV_EXT_RST), "external");
		chk(d & bit_of(EV_FAIL), bit_of(EV_FAIL), "failure");
		rd(OFS_STATE); chk(d, 8'h0A, "state");
		finish_test();
	end
endmodule
`default_nettype wire
